// ==== include/pio_pkg.sv ====
package pio_pkg;
  // Pin and port geometry
  localparam int NPIN = 24;
  localparam int NGEN = 4;
  localparam int PIN_W = 5;
  localparam int EXTERNAL_MEMORY_PORT_W = 15;

  // Register offsets, three consecutive bytes per group
  localparam logic [7:0] A_LATCH = 8'h00;
  localparam logic [7:0] A_ADSEL = 8'h04;
  localparam logic [7:0] A_OMODE = 8'h08;
  localparam logic [7:0] A_SKIP = 8'h0C;
  localparam logic [7:0] A_DRV = 8'h10;
  localparam logic [7:0] A_PADIN = 8'h14;
  localparam logic [7:0] A_CTRL = 8'h18;
  localparam logic [7:0] A_FSEL = 8'h19;

  // Reset values
  localparam logic [23:0] RST_LATCH = 24'hFFFFFF;
  localparam logic [23:0] RST_ADSEL = 24'hFFFFFF;
  localparam logic [23:0] RST_OMODE = 24'h000000;
  localparam logic [23:0] RST_SKIP = 24'h000000;
  localparam logic [23:0] RST_DRV = 24'h000000;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_FSEL = 8'h00;

  // Control and function select bit positions
  localparam int CB_XBAR = 0;
  localparam int CB_GPD = 1;
  localparam int CB_EXTERNAL_MEMORY_PORT = 2;
  localparam int CB_SPI4W = 3;
  localparam int FB_UART = 0;
  localparam int FB_SPI1 = 1;
  localparam int FB_GEN = 2;

  // Fixed pin placements
  localparam int UART_BASE = 4;
  localparam int SPI_BASE = 8;
  localparam int EXTERNAL_MEMORY_PORT_LO = 8;
  localparam logic [23:0] UART_MASK = 24'h000030;
  localparam logic [23:0] SPI3_MASK = 24'h000700;
  localparam logic [23:0] SPI4_MASK = 24'h000F00;
  localparam logic [23:0] EXTERNAL_MEMORY_PORT_MASK = 24'h7FFF00;
  localparam logic [23:0] DBG_MASK = 24'h800000;
  localparam logic [23:0] VREF_MASK = 24'h000001;
  localparam logic [23:0] ANALOG_GROUND_REF_MASK = 24'h000002;
  localparam logic [23:0] OSCI_MASK = 24'h000004;
  localparam logic [23:0] OSCO_MASK = 24'h000008;
  localparam logic [23:0] IREF_MASK = 24'h000080;
endpackage

// ==== core/pio_xbar_alloc.sv ====
`timescale 1ns/1ps
module pio_xbar_alloc
  import pio_pkg::*;
(
  // Pin availability
  input wire logic [NPIN-1:0] skip_i,
  input wire logic [NPIN-1:0] fixed_i,
  // Remaining function requests, highest priority first
  input wire logic [NGEN-1:0] gen_en_i,
  // Placement results
  output logic [NGEN*PIN_W-1:0] gen_pin_o,
  output logic [NGEN-1:0] gen_ok_o,
  output logic [NPIN-1:0] claim_o
);

  // Lowest free pin: found flag above the index
  function automatic logic [PIN_W:0] lowest_free(input logic [NPIN-1:0] avail);
    logic [PIN_W:0] r;
    r = '0;
    for (int i = NPIN - 1; i >= 0; i--) begin
      if (avail[i]) begin
        r = {1'b1, PIN_W'(i)};
      end
    end
    return r;
  endfunction

  // Walk functions in priority order, each taking the lowest free pin
  always_comb begin
    logic [NPIN-1:0] taken;
    logic [PIN_W:0] hit;
    taken = skip_i | fixed_i;
    hit = '0;
    gen_pin_o = '0;
    gen_ok_o = '0;
    claim_o = '0;
    for (int k = 0; k < NGEN; k++) begin
      hit = lowest_free(~taken);
      if (gen_en_i[k] && hit[PIN_W]) begin // see RULE18
        gen_ok_o[k] = 1'b1;
        gen_pin_o[k*PIN_W +: PIN_W] = hit[PIN_W-1:0];
        taken[hit[PIN_W-1:0]] = 1'b1;
        claim_o[hit[PIN_W-1:0]] = 1'b1;
      end
    end
  end

endmodule

// ==== core/pio_port_cfg.sv ====
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Three byte ports, 23 pins analog-or-digital
// RULE2 - Top pin of port 2 GPIO, shared debug
// RULE3 - Reset: digital, high impedance, pull-up on
// RULE4 - Analog pin: no pull-up, no receiver
// RULE5 - Analog pin reads back zero
// RULE6 - Software selects digital for digital uses
// RULE7 - Push-pull mode drives both levels
// RULE8 - Open-drain drives only low
// RULE9 - Pull-up on when floating, global disable
// RULE10 - Digital read returns pad level
// RULE11 - Per-pin drive strength, low at reset
// RULE12 - Skipped pins excluded from crossbar
// RULE13 - Software parks analog pins, sets skip
// RULE14 - Crossbar uses unskipped pins, fixed serial spots
// RULE15 - Analog reference and oscillator pins fixed
// RULE16 - Memory interface uses port 1-2 directly
// RULE17 - Software skips GPIO and bypass pins
// RULE18 - Others take lowest free pin in order
// RULE19 - Crossbar disabled turns every driver off; an active debug line still drives the top pin
// RULE20 - Unclaimed digital pin outputs its latch
module pio_port_cfg
  import pio_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Pads
  input wire logic [NPIN-1:0] pad_i,
  output logic [NPIN-1:0] pad_o,
  output logic [NPIN-1:0] pad_oe_o,
  output logic [NPIN-1:0] pullup_en_o,
  output logic [NPIN-1:0] drive_high_o,
  output logic [NPIN-1:0] rx_en_o,
  // Peripheral side
  output logic [NPIN-1:0] periph_in_o,
  input wire logic [5:0] fix_out_i,
  input wire logic [5:0] fix_oe_i,
  input wire logic [NGEN-1:0] gen_out_i,
  input wire logic [NGEN-1:0] gen_oe_i,
  input wire logic [EXTERNAL_MEMORY_PORT_W-1:0] external_memory_port_out_i,
  input wire logic [EXTERNAL_MEMORY_PORT_W-1:0] external_memory_port_oe_i,
  input wire logic [4:0] ana_en_i,
  // Debug data line on the top pin
  input wire logic dbg_active_i,
  input wire logic dbg_out_i,
  input wire logic dbg_oe_i
);

  logic [NPIN-1:0] latch_q, adsel_q, omode_q, skip_q, drv_q;
  logic [7:0] ctrl_q, fsel_q;
  logic [NPIN-1:0] val_d, oe_d, pu_d, fixc, fix_v, fix_e, external_memory_port_v, external_memory_port_e, ana_fix, skip_eff, gen_claim;
  logic [NGEN*PIN_W-1:0] gen_pin;
  logic [NGEN-1:0] gen_ok;
  logic [7:0] rdata_d;
  logic xbar_en, gpd, external_memory_port_on;

  // Hit test for a three-byte register group
  function automatic logic grp_hit(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'h03);
  endfunction

  // Byte of a 24-bit group selected by address
  function automatic logic [7:0] grp_byte(input logic [23:0] v, input logic [7:0] a, input logic [7:0] base);
    logic [7:0] s;
    s = a - base;
    return v[s[1:0]*8 +: 8];
  endfunction

  assign xbar_en = ctrl_q[CB_XBAR];
  assign gpd = ctrl_q[CB_GPD];
  assign external_memory_port_on = ctrl_q[CB_EXTERNAL_MEMORY_PORT];

  // Per-pin configuration bytes; top pin stays digital
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      latch_q <= RST_LATCH; // see RULE3
      adsel_q <= RST_ADSEL;
      omode_q <= RST_OMODE;
      skip_q <= RST_SKIP;
      drv_q <= RST_DRV; // see RULE11
    end else if (wr_i) begin
      for (int k = 0; k < 3; k++) begin
        if (addr_i == A_LATCH + 8'(k)) begin
          latch_q[k*8 +: 8] <= wdata_i;
        end else if (addr_i == A_ADSEL + 8'(k)) begin
          adsel_q[k*8 +: 8] <= wdata_i; // see RULE1
        end else if (addr_i == A_OMODE + 8'(k)) begin
          omode_q[k*8 +: 8] <= wdata_i;
        end else if (addr_i == A_SKIP + 8'(k)) begin
          skip_q[k*8 +: 8] <= wdata_i;
        end else if (addr_i == A_DRV + 8'(k)) begin
          drv_q[k*8 +: 8] <= wdata_i;
        end
      end
      if (addr_i == A_ADSEL + 8'h02) begin
        adsel_q[NPIN-1] <= 1'b1; // see RULE2
      end
    end
  end

  // Global control and crossbar function selects
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_q <= RST_CTRL;
      fsel_q <= RST_FSEL;
    end else if (wr_i && addr_i == A_CTRL) begin
      ctrl_q <= wdata_i;
    end else if (wr_i && addr_i == A_FSEL) begin
      fsel_q <= wdata_i;
    end
  end

  // Fixed placements; the debug pin never joins the crossbar
  always_comb begin
    fixc = '0;
    if (fsel_q[FB_UART]) begin
      fixc = fixc | UART_MASK; // see RULE14
    end
    if (fsel_q[FB_SPI1]) begin
      fixc = fixc | (ctrl_q[CB_SPI4W] ? SPI4_MASK : SPI3_MASK);
    end
    skip_eff = skip_q | DBG_MASK; // see RULE12
    ana_fix = (ana_en_i[0] ? VREF_MASK : '0) | (ana_en_i[1] ? ANALOG_GROUND_REF_MASK : '0) // see RULE15
      | (ana_en_i[2] ? OSCI_MASK : '0) | (ana_en_i[3] ? OSCO_MASK : '0)
      | (ana_en_i[4] ? IREF_MASK : '0);
    fix_v = (NPIN'(fix_out_i[1:0]) << UART_BASE) | (NPIN'(fix_out_i[5:2]) << SPI_BASE);
    fix_e = (NPIN'(fix_oe_i[1:0]) << UART_BASE) | (NPIN'(fix_oe_i[5:2]) << SPI_BASE);
    external_memory_port_v = NPIN'(external_memory_port_out_i) << EXTERNAL_MEMORY_PORT_LO;
    external_memory_port_e = NPIN'(external_memory_port_oe_i) << EXTERNAL_MEMORY_PORT_LO;
  end

  // Remaining functions placed by priority
  pio_xbar_alloc u_alloc (
    .skip_i(skip_eff),
    .fixed_i(fixc),
    .gen_en_i(fsel_q[FB_GEN +: NGEN]),
    .gen_pin_o(gen_pin),
    .gen_ok_o(gen_ok),
    .claim_o(gen_claim)
  );

  // Per-pin source, driver enable and pull-up
  always_comb begin
    logic en;
    en = 1'b1;
    for (int i = 0; i < NPIN; i++) begin
      val_d[i] = latch_q[i]; // see RULE20
      en = 1'b1;
      if (external_memory_port_on && EXTERNAL_MEMORY_PORT_MASK[i]) begin
        val_d[i] = external_memory_port_v[i]; // see RULE16
        en = external_memory_port_e[i];
      end else if (fixc[i]) begin
        val_d[i] = fix_v[i];
        en = fix_e[i];
      end else begin
        for (int k = 0; k < NGEN; k++) begin
          if (gen_ok[k] && gen_pin[k*PIN_W +: PIN_W] == PIN_W'(i)) begin
            val_d[i] = gen_out_i[k];
            en = gen_oe_i[k];
          end
        end
      end
      // Open drain only pulls low; push-pull drives both rails
      oe_d[i] = xbar_en && adsel_q[i] && !ana_fix[i] && en && (omode_q[i] || !val_d[i]); // see RULE7 RULE8 RULE19
      if (DBG_MASK[i] && dbg_active_i) begin
        val_d[i] = dbg_out_i; // see RULE2
        oe_d[i] = dbg_oe_i;
      end
      pu_d[i] = adsel_q[i] && !gpd && !(oe_d[i] && !val_d[i]); // see RULE4 RULE9
    end
  end

  // Pad outputs registered so every output comes from a flop
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pad_o <= RST_LATCH;
      pad_oe_o <= '0; // see RULE3
      pullup_en_o <= RST_ADSEL;
      drive_high_o <= RST_DRV;
      rx_en_o <= RST_ADSEL;
      periph_in_o <= '0;
    end else begin
      pad_o <= val_d;
      pad_oe_o <= oe_d;
      pullup_en_o <= pu_d;
      drive_high_o <= drv_q; // see RULE11
      rx_en_o <= adsel_q; // see RULE4
      periph_in_o <= pad_i & adsel_q;
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    if (grp_hit(addr_i, A_LATCH)) begin
      rdata_d = grp_byte(latch_q, addr_i, A_LATCH);
    end else if (grp_hit(addr_i, A_ADSEL)) begin
      rdata_d = grp_byte(adsel_q, addr_i, A_ADSEL);
    end else if (grp_hit(addr_i, A_OMODE)) begin
      rdata_d = grp_byte(omode_q, addr_i, A_OMODE);
    end else if (grp_hit(addr_i, A_SKIP)) begin
      rdata_d = grp_byte(skip_q, addr_i, A_SKIP);
    end else if (grp_hit(addr_i, A_DRV)) begin
      rdata_d = grp_byte(drv_q, addr_i, A_DRV);
    end else if (grp_hit(addr_i, A_PADIN)) begin
      // Pad level, not latch; analog pins masked to zero
      rdata_d = grp_byte(pad_i & adsel_q, addr_i, A_PADIN); // see RULE5 RULE10
    end else if (addr_i == A_CTRL) begin
      rdata_d = ctrl_q;
    end else if (addr_i == A_FSEL) begin
      rdata_d = fsel_q;
    end else begin
      rdata_d = '0;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rdata_d : 8'h00;
    end
  end

  // Helper: latch-driven push-pull GPIO pins
  logic [NPIN-1:0] gpio_pp;
  assign gpio_pp = {NPIN{xbar_en}} & adsel_q & omode_q & ~ana_fix & ~fixc & ~gen_claim
    & ~(external_memory_port_on ? EXTERNAL_MEMORY_PORT_MASK : '0) & ~DBG_MASK;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_reset_hiz: assert property ($past(sys_rst_i) |-> pad_oe_o == '0 && adsel_q == RST_ADSEL // see RULE3
    && pullup_en_o == RST_ADSEL) else $error("reset defaults wrong");
  a_top_digital: assert property (adsel_q[NPIN-1] && skip_eff[NPIN-1]) // see RULE2
    else $error("top pin left digital-only set");
  a_analog_off: assert property (((pullup_en_o | rx_en_o) & ~$past(adsel_q)) == '0) // see RULE4
    else $error("analog pin has pull-up or receiver");
  a_pad_readback: assert property (rd_i && addr_i == A_PADIN |=> rdata_o == $past(pad_i[7:0] & adsel_q[7:0])) // see RULE5
    else $error("pad readback mismatch");
  a_pp_drive: assert property (((~pad_oe_o | pad_o ^ $past(latch_q)) & $past(gpio_pp)) == '0) // see RULE7
    else $error("push-pull gpio not driving latch");
  a_od_no_high: assert property ((pad_oe_o & pad_o & ~$past(omode_q) & ~DBG_MASK) == '0) // see RULE8
    else $error("open-drain pin drove high");
  a_pullup_low: assert property ((pullup_en_o & pad_oe_o & ~pad_o) == '0 // see RULE9
    && ($past(gpd) -> pullup_en_o == '0)) else $error("pull-up on while low or disabled");
  a_drive_write: assert property (wr_i && addr_i == A_DRV |=> ##1 drive_high_o[7:0] == $past(wdata_i, 2)) // see RULE11
    else $error("drive strength not applied");
  a_skip_excl: assert property ((gen_claim & (skip_eff | fixc)) == '0) // see RULE12
    else $error("crossbar claimed skipped pin");
  a_xbar_off: assert property (!xbar_en && !dbg_active_i |=> pad_oe_o == '0) // see RULE19
    else $error("driver on with crossbar off");

  c_gen_placed: cover property (gen_ok[0] && xbar_en ##1 pad_oe_o != '0);
  c_external_memory_port_drive: cover property (external_memory_port_on && xbar_en && external_memory_port_oe_i != '0);
  c_pp_gpio: cover property (gpio_pp != '0 ##1 pad_oe_o != '0);

endmodule

// ==== bench/pio_pad_model.sv ====
`timescale 1ns/1ps
module pio_pad_model
  import pio_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Device side of the pads
  input wire logic [NPIN-1:0] pad_o_i,
  input wire logic [NPIN-1:0] pad_oe_i,
  input wire logic [NPIN-1:0] pullup_i,
  // External drivers on the board
  input wire logic [NPIN-1:0] ext_val_i,
  input wire logic [NPIN-1:0] ext_oe_i,
  // Resolved pad level
  output logic [NPIN-1:0] level_o
);
  logic [NPIN-1:0] last_q = '0;

  // History for undriven pins, so a stale level is never mistaken for a real one
  always_ff @(posedge clock_i) begin
    last_q <= level_o;
  end

  // Device driver wins, then the board, then the weak pull-up; otherwise the pin wanders
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe_i[i])
        level_o[i] = pad_o_i[i];
      else if (ext_oe_i[i])
        level_o[i] = ext_val_i[i];
      else if (pullup_i[i])
        level_o[i] = 1'b1;
      else
        level_o[i] = ~last_q[i];
    end
  end
endmodule

// ==== bench/port_io_pin_configuration_tb.sv ====
`timescale 1ns/1ps
module port_io_pin_configuration_tb
  import pio_pkg::*;
;
  logic clk, rst, wr, rd, dbg_act, dbg_out, dbg_oe;
  logic [7:0] addr, wdata, rdata, rv;
  logic [23:0] pad_lvl, pad_o, pad_oe, pu, dh, rx, ext_val, ext_oe, per_in;
  logic [5:0] fix_out, fix_oe;
  logic [3:0] gen_out, gen_oe;
  logic [14:0] external_memory_port_out, external_memory_port_oe;
  logic [4:0] ana_en;
  int n_mismatch = 0;
  int checked = 0;

  pio_port_cfg i_dut (.clock_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .pad_i(pad_lvl), .pad_o(pad_o), .pad_oe_o(pad_oe), .pullup_en_o(pu), .drive_high_o(dh),
    .rx_en_o(rx), .periph_in_o(per_in), .fix_out_i(fix_out), .fix_oe_i(fix_oe), .gen_out_i(gen_out),
    .gen_oe_i(gen_oe), .external_memory_port_out_i(external_memory_port_out), .external_memory_port_oe_i(external_memory_port_oe), .ana_en_i(ana_en),
    .dbg_active_i(dbg_act), .dbg_out_i(dbg_out), .dbg_oe_i(dbg_oe));

  pio_pad_model i_pads (.clock_i(clk), .pad_o_i(pad_o), .pad_oe_i(pad_oe), .pullup_i(pu),
    .ext_val_i(ext_val), .ext_oe_i(ext_oe), .level_o(pad_lvl));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Pad outputs follow register changes one edge later
  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    chk("oe", 24'h000000, pad_oe);
    chk("pullup", 24'hFFFFFF, pu);
    chk("rx", 24'hFFFFFF, rx);
    chk("drive", 24'h000000, dh);
    rd_reg(A_ADSEL + 8'h01, rv);
    chk("adsel", 24'h0000FF, {16'h0000, rv});
    rd_reg(8'h1F, rv);
    chk("unmapped", 24'h000000, {16'h0000, rv});
  endtask

  task automatic t_analog();
    wr_reg(A_SKIP, 8'h01);
    wr_reg(A_ADSEL, 8'hFE);
    ext_val <= 24'h000001;
    ext_oe <= 24'h000001;
    settle();
    chk("pullup", 24'hFFFFFE, pu);
    chk("rx", 24'hFFFFFE, rx);
    rd_reg(A_PADIN, rv);
    chk("padin", 24'h0000FE, {16'h0000, rv});
    wr_reg(A_ADSEL + 8'h02, 8'h00);
    rd_reg(A_ADSEL + 8'h02, rv);
    chk("adsel2", 24'h000080, {16'h0000, rv});
    wr_reg(A_ADSEL, 8'hFF);
    wr_reg(A_ADSEL + 8'h02, 8'hFF);
    ext_oe <= 24'h000000;
  endtask

  task automatic t_gpio();
    wr_reg(A_SKIP, 8'hFF);
    wr_reg(A_OMODE, 8'hFF);
    wr_reg(A_LATCH, 8'hA5);
    settle();
    chk("oe off", 24'h000000, pad_oe);
    wr_reg(A_CTRL, 8'h01);
    settle();
    chk("oe", 24'h0000FF, pad_oe);
    chk("out", 24'h0000A5, pad_o & 24'h0000FF);
    chk("pullup", 24'hFFFFA5, pu);
    rd_reg(A_PADIN, rv);
    chk("padin", 24'h0000A5, {16'h0000, rv});
    chk("periph in", 24'hFFFFA5, per_in);
    ana_en <= 5'h01;
    settle();
    chk("vref oe", 24'h000000, pad_oe & VREF_MASK);
    ana_en <= 5'h00;
  endtask

  task automatic t_odrain();
    wr_reg(A_OMODE, 8'h00);
    wr_reg(A_LATCH, 8'h0F);
    ext_val <= 24'h000000;
    ext_oe <= 24'h000001;
    settle();
    chk("oe", 24'h0000F0, pad_oe);
    chk("pullup", 24'hFFFF0F, pu);
    rd_reg(A_PADIN, rv);
    chk("padin", 24'h00000E, {16'h0000, rv});
    wr_reg(A_CTRL, 8'h03);
    settle();
    chk("pullup off", 24'h000000, pu);
    wr_reg(A_CTRL, 8'h01);
    ext_oe <= 24'h000000;
  endtask

  task automatic t_uart();
    wr_reg(A_DRV + 8'h01, 8'h3C);
    wr_reg(A_SKIP, 8'h00);
    wr_reg(A_OMODE, 8'hFF);
    wr_reg(A_FSEL, 8'h01);
    fix_oe <= 6'h03;
    fix_out <= 6'h01;
    settle();
    chk("drive", 24'h003C00, dh);
    chk("uart oe", UART_MASK, pad_oe & UART_MASK);
    chk("uart out", 24'h000010, pad_o & UART_MASK);
  endtask

  // Priority placement takes the lowest free pin; memory port bypasses the crossbar
  task automatic t_gen();
    wr_reg(A_FSEL, 8'h05);
    gen_oe <= 4'h1;
    gen_out <= 4'h0;
    settle();
    chk("gen oe", 24'h000001, pad_oe & 24'h000001);
    chk("gen out", 24'h000000, pad_o & 24'h000001);
    wr_reg(A_SKIP, 8'h01);
    settle();
    chk("gen skip oe", 24'h000003, pad_oe & 24'h000003);
    chk("gen skip out", 24'h000001, pad_o & 24'h000003);
    wr_reg(A_CTRL, 8'h05);
    external_memory_port_oe <= 15'h0001;
    external_memory_port_out <= 15'h0000;
    settle();
    chk("external_memory_port oe", 24'h000100, pad_oe & 24'h000100);
    chk("external_memory_port out", 24'h000000, pad_o & 24'h000100);
  endtask

  task automatic t_debug();
    wr_reg(A_CTRL, 8'h00);
    dbg_act <= 1'b1;
    dbg_oe <= 1'b1;
    dbg_out <= 1'b0;
    settle();
    chk("dbg oe", DBG_MASK, pad_oe);
    chk("dbg out", 24'h000000, pad_o & DBG_MASK);
  endtask

  // Main sequence
  initial begin
    {rst, wr, rd, dbg_act, dbg_out, dbg_oe} = 6'h20;
    {addr, wdata} = 16'h0000;
    {ext_val, ext_oe} = 48'h0;
    {fix_out, fix_oe, gen_out, gen_oe, external_memory_port_out, external_memory_port_oe, ana_en} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_analog();
    t_gpio();
    t_odrain();
    t_uart();
    t_gen();
    t_debug();
    finish_test();
  end

  // Hang guard
  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end
endmodule
